/* File: hdl/dmr_mode_regs.sv */
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Self-refresh/termination register holds value until rewritten; array untouched.
// - CAS write latency comes from bits 5 to 3.
// - Total write latency is CAS write latency plus additive latency.
// - Bit 6 set lets self refresh go 2x automatically when hot.
// - Bit 7 set forces 2x self refresh always; clear means 1x unless bit 6 auto switching applies.
// - Bits 10:9 select write termination; nonzero enables dynamic switching.
// - Write termination replaces nominal during write bursts only; here it holds from the write command to burst end.
// - Nominal disabled gives high impedance outside writes.
// - Nominal and write termination enable independently.
// - No write termination during write leveling.
// - Bit 2 clear is normal; set selects pattern by bits 1:0.
// - With readout on, reads go to the pattern register.
// - Reset still works in readout mode.
// - Calibration pattern is 0,1,0,1 alternating on every burst.
// - Bank bits 010 select self-refresh register, 011 readout register.
module dmr_mode_regs
  import dmr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic csN,
  input wire logic rasN,
  input wire logic casN,
  input wire logic weN,
  input wire logic [2:0] bankAddr,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [1:0] additiveLatency,
  input wire logic [2:0] nominalTermSel,
  input wire logic writeLevelEn,
  input wire logic caseHot,
  input wire logic caseWarm,
  output logic [CWL_W-1:0] casWriteLatency,
  output logic [LAT_W-1:0] totalWriteLatency,
  output logic doubleRefreshRate,
  output logic [2:0] termSel,
  output logic termWriteActive,
  output logic patternRead,
  output logic patternDataValid,
  output logic patternData,
  output logic arrayReadEn
);
  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  logic [ADDR_W+6:0] pinMeta_r;
  logic [ADDR_W+6:0] pinSync_r;
  logic hotMeta_r;
  logic hotSync_r;
  logic warmMeta_r;
  logic warmSync_r;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pinMeta_r <= {4'hF, {(ADDR_W+3){1'b0}}};
      pinSync_r <= {4'hF, {(ADDR_W+3){1'b0}}};
    end else begin
      pinMeta_r <= {csN, rasN, casN, weN, bankAddr, addr};
      pinSync_r <= pinMeta_r;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      hotMeta_r <= 1'b0;
      hotSync_r <= 1'b0;
      warmMeta_r <= 1'b0;
      warmSync_r <= 1'b0;
    end else begin
      hotMeta_r <= caseHot;
      hotSync_r <= hotMeta_r;
      warmMeta_r <= caseWarm;
      warmSync_r <= warmMeta_r;
    end
  end

  logic [3:0] cmdS;
  logic [2:0] bankS;
  logic [ADDR_W-1:0] addrS;
  assign cmdS = pinSync_r[ADDR_W+6:ADDR_W+3];
  assign bankS = pinSync_r[ADDR_W+2:ADDR_W];
  assign addrS = pinSync_r[ADDR_W-1:0];

  logic isMrs;
  logic isWrite;
  logic isRead;
  assign isMrs = (cmdS == CMD_MRS);
  assign isWrite = (cmdS == CMD_WRITE);
  assign isRead = (cmdS == CMD_READ);

  // ==========================================================
  // Mode registers (write-only, no readback path)
  // ==========================================================
  logic [CWL_W-1:0] cwl_r;
  logic asr_r;
  logic srt_r;
  logic [WTERM_W-1:0] wterm_r;
  logic rdoEn_r;
  logic [RDO_SEL_W-1:0] rdoSel_r;

  // Array contents are elsewhere; only these fields change here
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cwl_r <= CWL_RESET;
      asr_r <= 1'b0;
      srt_r <= 1'b0;
      wterm_r <= WTERM_OFF;
    end else if (isMrs && bankS == BANK_SEL_SRT) begin
      cwl_r <= addrS[CWL_LSB +: CWL_W];
      asr_r <= addrS[ASR_BIT];
      srt_r <= addrS[SRT_BIT];
      wterm_r <= addrS[WTERM_LSB +: WTERM_W];
    end
  end

  // Reset clears readout mode even when enabled
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdoEn_r <= 1'b0;
      rdoSel_r <= RDO_SEL_PATTERN;
    end else if (isMrs && bankS == BANK_SEL_RDO) begin
      rdoEn_r <= addrS[RDO_EN_BIT];
      rdoSel_r <= addrS[RDO_SEL_LSB +: RDO_SEL_W];
    end
  end

  assign casWriteLatency = cwl_r;

  // ==========================================================
  // Self refresh rate
  // ==========================================================
  // Warm threshold sits below the hot point, so switch may come early
  logic dblRate_r;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dblRate_r <= 1'b0;
    end else begin
      dblRate_r <= srt_r || (asr_r && (hotSync_r || warmSync_r));
    end
  end
  assign doubleRefreshRate = dblRate_r;

  // ==========================================================
  // Write latency and write termination window
  // ==========================================================
  // CAS_WRITE_LATENCY code 0 means 5 clocks; latency = CAS_WRITE_LATENCY + AL
  logic [LAT_W-1:0] wlNxt;
  assign wlNxt = LAT_W'(CWL_BASE) + LAT_W'(cwl_r) + LAT_W'(additiveLatency);
  assign totalWriteLatency = wlNxt;

  logic dataStart;
  dmr_delay_line #(.DEPTH(32)) dmr_delay_line_inst (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .pulseIn(isWrite && !rdoEn_r),
    .delaySel(wlNxt - LAT_W'(1)),
    .pulseOut(dataStart)
  );

  logic [3:0] burstCnt_r;
  logic inWrite_r;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      inWrite_r <= 1'b0;
      burstCnt_r <= 4'h0;
    end else if (isWrite && !rdoEn_r) begin
      inWrite_r <= 1'b1;
      burstCnt_r <= 4'h0;
    end else if (dataStart) begin
      burstCnt_r <= 4'(BURST_LEN / 2);
    end else if (burstCnt_r != 4'h0) begin
      burstCnt_r <= burstCnt_r - 4'h1;
      if (burstCnt_r == 4'h1) begin
        inWrite_r <= 1'b0;
      end
    end
  end

  // Encoding: 0 high-Z, else nominal code, or {1,wterm} during writes
  logic wtActive;
  assign wtActive = inWrite_r && (wterm_r != WTERM_OFF) && !writeLevelEn;
  logic [2:0] term_r;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      term_r <= 3'h0;
    end else if (wtActive) begin
      term_r <= {1'b1, wterm_r};
    end else begin
      term_r <= nominalTermSel;
    end
  end
  assign termSel = term_r;
  assign termWriteActive = wtActive;

  // ==========================================================
  // Pattern readout
  // ==========================================================
  logic [7:0] patShift_r;
  logic [3:0] patCnt_r;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      patShift_r <= 8'h00;
      patCnt_r <= 4'h0;
    end else if (isRead && rdoEn_r) begin
      // Only the calibration code is defined; others return zero
      patShift_r <= (rdoSel_r == RDO_SEL_PATTERN) ? CAL_PATTERN : 8'h00;
      patCnt_r <= 4'(BURST_LEN);
    end else if (patCnt_r != 4'h0) begin
      patShift_r <= {1'b0, patShift_r[7:1]};
      patCnt_r <= patCnt_r - 4'h1;
    end
  end

  // Valid is registered with the data bit so both line up on every beat
  logic patBit_r;
  logic patValid_r;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      patBit_r <= 1'b0;
      patValid_r <= 1'b0;
    end else begin
      patBit_r <= (patCnt_r != 4'h0) ? patShift_r[0] : 1'b0;
      patValid_r <= (patCnt_r != 4'h0);
    end
  end
  assign patternData = patBit_r;
  assign patternDataValid = patValid_r;
  assign patternRead = rdoEn_r;
  assign arrayReadEn = isRead && !rdoEn_r;

  // ==========================================================
  // Assertions
  // ==========================================================
  sequence s_rdoRead;
    isRead && rdoEn_r && rdoSel_r == RDO_SEL_PATTERN;
  endsequence
  sequence s_altBits;
    (patternDataValid && patBit_r == 1'b0) ##1 (patBit_r == 1'b1);
  endsequence

  property p_cwlLoad;
    @(posedge ref_clk) disable iff (!nrst)
      isMrs && bankS == BANK_SEL_SRT |=> cwl_r == $past(addrS[CWL_LSB +: CWL_W]);
  endproperty
  a_cwlLoad: assert property (p_cwlLoad) else $error("cas latency not loaded");

  property p_hold;
    @(posedge ref_clk) disable iff (!nrst)
      !(isMrs && bankS == BANK_SEL_SRT) |=> $stable(cwl_r) && $stable(wterm_r);
  endproperty
  a_hold: assert property (p_hold) else $error("mode field changed w/o write");

  property p_wl;
    @(posedge ref_clk) disable iff (!nrst)
      totalWriteLatency == LAT_W'(CWL_BASE) + LAT_W'(cwl_r) + LAT_W'(additiveLatency);
  endproperty
  a_wl: assert property (p_wl) else $error("write latency mismatch");

  property p_srt;
    @(posedge ref_clk) disable iff (!nrst)
      srt_r && $past(srt_r) |-> doubleRefreshRate;
  endproperty
  a_srt: assert property (p_srt) else $error("forced 2x not applied");

  property p_normRate;
    @(posedge ref_clk) disable iff (!nrst)
      !srt_r && !asr_r && !$past(srt_r) && !$past(asr_r) |-> !doubleRefreshRate;
  endproperty
  a_normRate: assert property (p_normRate) else $error("2x without enable");

  property p_levelNoWt;
    @(posedge ref_clk) disable iff (!nrst)
      writeLevelEn |-> !termWriteActive;
  endproperty
  a_levelNoWt: assert property (p_levelNoWt) else $error("write term in leveling");

  property p_nomOutside;
    @(posedge ref_clk) disable iff (!nrst)
      !wtActive |=> termSel == $past(nominalTermSel);
  endproperty
  a_nomOutside: assert property (p_nomOutside) else $error("nominal not restored");

  property p_redirect;
    @(posedge ref_clk) disable iff (!nrst)
      isRead && rdoEn_r |-> !arrayReadEn ##2 patternDataValid [*8];
  endproperty
  a_redirect: assert property (p_redirect) else $error("read not redirected");

  property p_pattern;
    @(posedge ref_clk) disable iff (!nrst)
      s_rdoRead ##1 !(isRead && rdoEn_r) |=> s_altBits;
  endproperty
  a_pattern: assert property (p_pattern) else $error("pattern not alternating");
endmodule
`default_nettype wire

/* File: hdl/dmr_pkg.sv */
package dmr_pkg;
  // ==========================================================
  // Command decode (registered command bus, active-low pins)
  // ==========================================================
  localparam logic [2:0] BANK_SEL_SRT = 3'h2;
  localparam logic [2:0] BANK_SEL_RDO = 3'h3;
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam int ADDR_W = 17;
  // ==========================================================
  // Self-refresh/termination register fields
  // ==========================================================
  localparam int CWL_LSB = 3;
  localparam int CWL_W = 3;
  localparam int ASR_BIT = 6;
  localparam int SRT_BIT = 7;
  localparam int WTERM_LSB = 9;
  localparam int WTERM_W = 2;
  localparam logic [WTERM_W-1:0] WTERM_OFF = 2'h0;
  localparam logic [CWL_W-1:0] CWL_RESET = 3'h0;
  localparam int CWL_BASE = 5;
  // ==========================================================
  // Readout register fields
  // ==========================================================
  localparam int RDO_EN_BIT = 2;
  localparam int RDO_SEL_LSB = 0;
  localparam int RDO_SEL_W = 2;
  localparam logic [RDO_SEL_W-1:0] RDO_SEL_PATTERN = 2'h0;
  localparam logic [7:0] CAL_PATTERN = 8'hAA;
  localparam int BURST_LEN = 8;
  localparam int LAT_W = 5;
endpackage

/* File: hdl/dmr_delay_line.sv */
`timescale 1ns/10ps
`default_nettype none
module dmr_delay_line
  import dmr_pkg::*;
#(
  parameter int DEPTH = 32
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic pulseIn,
  input wire logic [LAT_W-1:0] delaySel,
  output logic pulseOut
);
  // ==========================================================
  // Shift chain, tap picks the latency
  // ==========================================================
  logic [DEPTH-1:0] chain_r;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      chain_r <= '0;
    end else begin
      chain_r <= {chain_r[DEPTH-2:0], pulseIn};
    end
  end

  // Tap 0 means one clock; zero-delay would need a combinational path
  assign pulseOut = chain_r[delaySel];
endmodule
`default_nettype wire

/* File: verif/dmr_ctrl_model.sv */
`timescale 1ns/10ps
`default_nettype none
module dmr_ctrl_model
  import dmr_pkg::*;
#(
  parameter int MOD_GAP = 12
) (
  input wire logic ref_clk,
  output logic csN,
  output logic rasN,
  output logic casN,
  output logic weN,
  output logic [2:0] bankAddr,
  output logic [ADDR_W-1:0] addr
);
  // ==========================================================
  // Command issue
  // ==========================================================
  initial begin
    {csN, rasN, casN, weN} = 4'hF;
    bankAddr = 3'h0;
    addr = '0;
  end
  // Deselected lines show inverted data so stale values never pass
  task automatic issue(input logic [3:0] cmd, input logic [2:0] ba,
    input logic [ADDR_W-1:0] a, input int gap);
    @(posedge ref_clk) #1;
    {csN, rasN, casN, weN} = cmd;
    bankAddr = ba;
    addr = a;
    @(posedge ref_clk) #1;
    csN = 1'b1;
    bankAddr = ~ba;
    addr = ~a;
    repeat (gap) @(posedge ref_clk) #1;
  endtask
  // Reserved bits zero; forced rate dropped if auto is also asked
  task automatic set_srt(input logic [2:0] cas_write_latency, input logic auto_self_refresh, input logic forced_double_refresh,
    input logic [1:0] wt);
    issue(CMD_MRS, BANK_SEL_SRT, {6'h0, wt, 1'b0, forced_double_refresh & ~auto_self_refresh, auto_self_refresh, cas_write_latency, 3'h0},
      MOD_GAP);
  endtask
  // No bank is ever opened, so all banks stay precharged
  task automatic set_rdo(input logic en, input logic [1:0] sel);
    issue(CMD_MRS, BANK_SEL_RDO, {14'h0, en, sel}, MOD_GAP);
  endtask
  // Reads use column bits 1:0 of zero; used with readout both on and off
  task automatic rd();
    issue(CMD_READ, 3'h0, '0, 0);
  endtask
endmodule
`default_nettype wire

/* File: verif/dmr_mode_regs_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module dmr_mode_regs_tb
  import dmr_pkg::*;
;
  logic ref_clk = 1'b0, nrst = 1'b0, writeLevelEn = 1'b0, caseHot = 1'b0, caseWarm = 1'b0;
  logic [1:0] additiveLatency = 2'h0;
  logic [2:0] nominalTermSel = 3'h0;
  logic csN, rasN, casN, weN, doubleRefreshRate, termWriteActive, patternRead;
  logic patternDataValid, patternData, arrayReadEn;
  logic [2:0] bankAddr, casWriteLatency, termSel;
  logic [ADDR_W-1:0] addr;
  logic [LAT_W-1:0] totalWriteLatency;
  int fail_count = 0, n_checks = 0;
  always #2 ref_clk = ~ref_clk;
  dmr_ctrl_model dmr_ctrl_model_inst (.ref_clk(ref_clk), .csN(csN), .rasN(rasN),
    .casN(casN), .weN(weN), .bankAddr(bankAddr), .addr(addr));
  dmr_mode_regs dmr_mode_regs_inst (.ref_clk(ref_clk), .nrst(nrst), .csN(csN),
    .rasN(rasN), .casN(casN), .weN(weN), .bankAddr(bankAddr), .addr(addr),
    .additiveLatency(additiveLatency), .nominalTermSel(nominalTermSel),
    .writeLevelEn(writeLevelEn), .caseHot(caseHot), .caseWarm(caseWarm),
    .casWriteLatency(casWriteLatency), .totalWriteLatency(totalWriteLatency),
    .doubleRefreshRate(doubleRefreshRate), .termSel(termSel),
    .termWriteActive(termWriteActive), .patternRead(patternRead),
    .patternDataValid(patternDataValid), .patternData(patternData),
    .arrayReadEn(arrayReadEn));
  // ==========================================================
  // Helpers
  // ==========================================================
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic wr_watch(output logic act, output logic [2:0] ts);
    act = 1'b0;
    ts = 3'h0;
    dmr_ctrl_model_inst.issue(CMD_WRITE, 3'h0, '0, 0);
    repeat (40) begin
      @(posedge ref_clk) #1;
      if (termWriteActive === 1'b1 && act === 1'b0) begin
        act = 1'b1;
        @(posedge ref_clk) #1;
        ts = termSel;
      end
    end
  endtask
  // Collects every bit seen while valid is high, LSB first
  task automatic rd_burst(output logic [7:0] pat, output logic [7:0] n, output logic arr);
    pat = 8'h00;
    n = 8'h00;
    arr = 1'b0;
    dmr_ctrl_model_inst.rd();
    repeat (30) begin
      @(posedge ref_clk) #1;
      arr = arr | arrayReadEn;
      if (patternDataValid === 1'b1) begin
        pat[n[2:0]] = patternData;
        n++;
      end
    end
  endtask
  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_latency();
    for (int i = 0; i < 8; i++) begin
      additiveLatency = 2'(i % 4);
      dmr_ctrl_model_inst.set_srt(3'(i), 1'b0, 1'b0, 2'h0);
      check("cwl", {5'h0, casWriteLatency}, 8'(i));
      check("wl", {3'h0, totalWriteLatency}, 8'(5 + i + i % 4));
    end
    additiveLatency = 2'h0;
  endtask
  task automatic t_refresh();
    logic [4:0] tbl [6] = '{5'h00, 5'h06, 5'h10, 5'h15, 5'h13, 5'h09};
    foreach (tbl[k]) begin
      {caseHot, caseWarm} = {tbl[k][2], tbl[k][1]};
      dmr_ctrl_model_inst.set_srt(3'h0, tbl[k][4], tbl[k][3], 2'h0);
      check("rate2x", {7'h0, doubleRefreshRate}, {7'h0, tbl[k][0]});
    end
  endtask
  task automatic t_term();
    logic a;
    logic [2:0] ts;
    nominalTermSel = 3'h3;
    dmr_ctrl_model_inst.set_srt(3'h0, 1'b0, 1'b0, 2'h1);
    check("termNom", {5'h0, termSel}, 8'h03);
    wr_watch(a, ts);
    check("wtOn", {7'h0, a}, 8'h01);
    check("wtSel", {5'h0, ts}, 8'h05);
    check("termBack", {5'h0, termSel}, 8'h03);
    nominalTermSel = 3'h0;
    repeat (4) @(posedge ref_clk) #1;
    check("termHiZ", {5'h0, termSel}, 8'h00);
    wr_watch(a, ts);
    check("wtNoNom", {5'h0, ts}, 8'h05);
    writeLevelEn = 1'b1;
    wr_watch(a, ts);
    check("wtLevel", {7'h0, a}, 8'h00);
    writeLevelEn = 1'b0;
    dmr_ctrl_model_inst.set_srt(3'h2, 1'b0, 1'b0, WTERM_OFF);
    wr_watch(a, ts);
    check("wtOff", {7'h0, a}, 8'h00);
    // Wrong bank must leave the stored latency alone
    dmr_ctrl_model_inst.issue(CMD_MRS, 3'h1, 17'h00038, 12);
    check("bankSel", {5'h0, casWriteLatency}, 8'h02);
  endtask
  task automatic t_readout();
    logic [7:0] p, n;
    logic ar;
    dmr_ctrl_model_inst.set_rdo(1'b1, RDO_SEL_PATTERN);
    check("rdoOn", {7'h0, patternRead}, 8'h01);
    rd_burst(p, n, ar);
    check("calPat", p, 8'hAA);
    check("calLen", n, 8'h08);
    check("noArray", {7'h0, ar}, 8'h00);
    dmr_ctrl_model_inst.set_rdo(1'b1, 2'h1);
    rd_burst(p, n, ar);
    check("otherSel", p, 8'h00);
    @(posedge ref_clk) #1;
    nrst = 1'b0;
    repeat (2) @(posedge ref_clk) #1;
    check("rstRdo", {7'h0, patternRead}, 8'h00);
    nrst = 1'b1;
    dmr_ctrl_model_inst.set_rdo(1'b1, RDO_SEL_PATTERN);
    dmr_ctrl_model_inst.set_rdo(1'b0, 2'h3);
    rd_burst(p, n, ar);
    check("arrRead", {7'h0, ar}, 8'h01);
    check("noPat", n, 8'h00);
  endtask
  // ==========================================================
  // Main sequence and watchdog
  // ==========================================================
  initial begin
    repeat (3) @(posedge ref_clk);
    #1 nrst = 1'b1;
    t_latency();
    t_refresh();
    t_term();
    t_readout();
    report_and_stop();
  end
  // Whole run is under a thousand cycles; this leaves wide margin
  initial begin
    #80000;
    fail_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
